// ### bias_regs_defines.vh
// Purpose: Constants for the page 1 bias load and live status register bank
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses = 4 * index
// Notes: Register index and field list follows
`ifndef BIAS_REGS_DEFINES_VH
`define BIAS_REGS_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_PAGE_SELECT 8'h00
`define IDX_SINK_CFG 8'h16
`define IDX_LIVE0 8'h2C
`define IDX_CH_SUMMARY 8'h2D
`define IDX_IRQ_STATUS 8'h40
`define IDX_IRQ_MASK 8'h41
`define BANK_PAGE 8'h01

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SINK_MODE_BIT 7
`define SINK_CODE_HI 6
`define SINK_CODE_LO 4
`define SINK_CFG_WMASK 8'hF0
`define SINK_CODE_RST 3'h0
`define REG_RST 8'h00
`define SINK_STEP_UA 16'h10CC
`define IRQ_BITS 6

`endif

// ### bias_status_regs.v
// Purpose: Page 1 register bank for bias load sink and live fault status
// Assumes: Classic Wishbone, 32-bit data, one-cycle registered ack
// Notes: Live bits reflect present conditions; sticky copies drive the irq
//
// Decided for this implementation: register access over Wishbone.
`default_nettype none
`include "bias_regs_defines.vh"
module bias_status_regs #(
	parameter ADDR_W = 10
)(
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [ADDR_W-1:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output wire irq_o,
	input wire clk_error_i,
	input wire pll_lock_i,
	input wire over_temp_i,
	input wire over_current_i,
	input wire [7:0] ch1_faults_i,
	input wire [7:0] ch2_faults_i,
	input wire vbat_short_low_i,
	input wire [2:0] auto_sink_code_i,
	output wire [7:0] page_o,
	output wire sink_manual_mode_o,
	output wire [2:0] sink_code_o,
	output wire [15:0] sink_current_ua_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] page_select;
	reg load_sink_manual_mode;
	reg [2:0] load_sink_current_code;
	reg [5:0] irq_status;
	reg [5:0] irq_mask;
	reg [5:0] live_prev;
	wire [6:0] live_sync;
	wire [7:0] live_fault_readback0;
	wire [7:0] channel_fault_summary_live;
	wire [5:0] live_events;
	wire [7:0] index;
	wire on_bank;
	wire req;
	wire wr;
	reg [7:0] next_rdata;

	// ----------------------------------------
	// Live inputs
	// ----------------------------------------
	live_status_sync #(.WIDTH(7)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({clk_error_i, pll_lock_i, over_temp_i, over_current_i,
			|ch1_faults_i, |ch2_faults_i, vbat_short_low_i}),
		.sync_o(live_sync)
	);

	// Present conditions only, nothing latched here
	assign live_fault_readback0 = {live_sync[6:3], 4'h0};
	// Summary ORs each channel's fault bits
	assign channel_fault_summary_live = {live_sync[2:1], 4'h0, live_sync[0],
		1'b0};
	assign live_events = {live_sync[6:3], live_sync[2:1]};

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign index = adr_i[9:2];
	// Page select lives on every page; the rest only on the bank's page
	assign on_bank = (page_select == `BANK_PAGE);
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr = req & we_i & sel_i[0];

	// Writes; reserved low bits of sink config have no storage
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			page_select <= `REG_RST;
			load_sink_manual_mode <= 1'b0;
			load_sink_current_code <= `SINK_CODE_RST;
			irq_mask <= 6'h00;
		end
		else if (wr)
		begin
			if (index == `IDX_PAGE_SELECT)
				page_select <= dat_i[7:0];
			if (on_bank && index == `IDX_SINK_CFG)
			begin
				load_sink_manual_mode <= dat_i[`SINK_MODE_BIT];
				load_sink_current_code <=
					dat_i[`SINK_CODE_HI:`SINK_CODE_LO];
			end
			if (on_bank && index == `IDX_IRQ_MASK)
				irq_mask <= dat_i[5:0];
		end
	end

	// Sticky bits set on rising live conditions; set wins over clear
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_status <= 6'h00;
			live_prev <= 6'h00;
		end
		else
		begin
			live_prev <= live_events;
			if (wr && on_bank && index == `IDX_IRQ_STATUS)
				irq_status <= (irq_status & ~dat_i[5:0]) |
					(live_events & ~live_prev);
			else
				irq_status <= irq_status | (live_events & ~live_prev);
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// Read mux; unmapped or other-page offsets read zero
	always @*
	begin
		next_rdata = 8'h00;
		if (index == `IDX_PAGE_SELECT)
			next_rdata = page_select;
		else if (on_bank)
		begin
			case (index)
			`IDX_SINK_CFG:
				next_rdata = {load_sink_manual_mode, load_sink_current_code,
					4'h0};
			`IDX_LIVE0:
				next_rdata = live_fault_readback0;
			`IDX_CH_SUMMARY:
				next_rdata = channel_fault_summary_live;
			`IDX_IRQ_STATUS:
				next_rdata = {2'b00, irq_status};
			`IDX_IRQ_MASK:
				next_rdata = {2'b00, irq_mask};
			default:
				next_rdata = 8'h00;
			endcase
		end
	end

	// Ack one cycle after the request, then drop
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= req;
			if (req)
				dat_o <= {24'h00_0000, next_rdata};
		end
	end

	// ----------------------------------------
	// Sink control
	// ----------------------------------------
	sink_current_calc u_sink (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.manual_mode_i(load_sink_manual_mode),
		.manual_code_i(load_sink_current_code),
		.auto_code_i(auto_sink_code_i),
		.sink_code_o(sink_code_o),
		.sink_current_ua_o(sink_current_ua_o)
	);

	assign page_o = page_select;
	assign sink_manual_mode_o = load_sink_manual_mode;
endmodule
`default_nettype wire

// ### bias_status_regs_assertions.sv
// Purpose: Bus and output checks for the bias status bank
// Assumes: Sees only the top module's ports
// Notes: Bound to every instance of the bank
`default_nettype none
module bias_status_regs_chk #(
	parameter ADDR_W = 10
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [2:0] auto_sink_code_i,
	input wire logic [7:0] page_o,
	input wire logic sink_manual_mode_o,
	input wire logic [2:0] sink_code_o,
	input wire logic [15:0] sink_current_ua_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Reset blocks all checks; $past guards cover the release edge
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_follows_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	ack_one_cycle_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_has_req_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	data_holds_a: assert property (!ack_o |-> $stable(dat_o))
		else $error("read data moved between requests");
	page_write_a: assert property (ack_o && $past(we_i && sel_i[0]
		&& adr_i[ADDR_W-1:2] == 8'h00) |-> page_o == $past(dat_i[7:0]))
		else $error("page select not written");
	mode_write_a: assert property (ack_o && $past(we_i && sel_i[0]
		&& adr_i[ADDR_W-1:2] == 8'h16 && page_o == 8'h01)
		|-> sink_manual_mode_o == $past(dat_i[7]))
		else $error("sink mode not written");
	auto_code_a: assert property (!sink_manual_mode_o && !rst_i ##1
		!sink_manual_mode_o |-> sink_code_o == $past(auto_sink_code_i))
		else $error("auto code not followed");
	current_scale_a: assert property ($stable(sink_code_o) [*2]
		|-> sink_current_ua_o == sink_code_o * 16'd4300)
		else $error("sink current not code times step");
	cover property (ack_o && $past(we_i));
	cover property (ack_o && !$past(we_i));
	cover property (sink_manual_mode_o);
endmodule
bind bias_status_regs bias_status_regs_chk #(.ADDR_W(ADDR_W)) chk_i (.*);
`default_nettype wire

// ### live_status_sync.v
// Purpose: Two-flop register stage for live fault and status inputs
// Assumes: Inputs may be asynchronous to clk_i
// Notes: First stage is read only by the second stage
`default_nettype none
module live_status_sync #(
	parameter WIDTH = 8
)(
	input wire clk_i,
	input wire rst_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;

	// Double flop; reset clears both so live bits read zero after reset
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stage1 <= {WIDTH{1'b0}};
			stage2 <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1 <= async_i;
			stage2 <= stage1;
		end
	end

	assign sync_o = stage2;
endmodule
`default_nettype wire

// ### sink_current_calc.v
// Purpose: Maps the sink mode and code to an effective sink setting
// Assumes: Auto code is supplied by the device configuration logic
// Notes: Current is given in microamps, code times 4300
`default_nettype none
`include "bias_regs_defines.vh"
module sink_current_calc (
	input wire clk_i,
	input wire rst_i,
	input wire manual_mode_i,
	input wire [2:0] manual_code_i,
	input wire [2:0] auto_code_i,
	output reg [2:0] sink_code_o,
	output reg [15:0] sink_current_ua_o
);
	reg [2:0] next_code;

	// Mode 0 ignores the manual code entirely
	always @*
	begin
		if (manual_mode_i)
			next_code = manual_code_i;
		else
			next_code = auto_code_i;
	end

	// Registered so downstream analog trims see a glitch-free value
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sink_code_o <= `SINK_CODE_RST;
			sink_current_ua_o <= 16'h0000;
		end
		else
		begin
			sink_code_o <= next_code;
			sink_current_ua_o <= next_code * `SINK_STEP_UA;
		end
	end
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the bias status bank
// Assumes: Host model drives the bus, bench drives the live inputs
// Notes: Expected values come from a small integer model of the bank
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, cyc, we, ack_o, irq_o, s;
	logic [9:0] adr;
	logic [3:0] sel;
	logic [31:0] wd, dat_o, rv, r2;
	logic clk_error_i = 0, pll_lock_i = 0, over_temp_i = 0;
	logic over_current_i = 0, vbat_short_low_i = 0, sink_manual_mode_o;
	logic [7:0] ch1_faults_i = 0, ch2_faults_i = 0, page_o, d;
	logic [2:0] auto_sink_code_i = 0, sink_code_o, ec;
	logic [15:0] sink_current_ua_o;
	int mismatches = 0, total_checks = 0, cfg = 0;
	bit to;
	initial forever #2 clk_i = ~clk_i;
	bias_status_regs bias_status_regs_i (.*, .cyc_i(cyc), .stb_i(cyc),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd));
	wb_host wb_host_i (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o),
		.cyc_o(cyc), .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wd));
	task automatic chk(string n, logic [31:0] sn, logic [31:0] e);
		total_checks++;
		if (sn !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, sn);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// A stuck bus ends the run at once
	task automatic bus(logic w, logic [7:0] i, logic [7:0] v, logic e = 1);
		wb_host_i.xfer(w, i, v, e, rv, to);
		if (to)
		begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic rdc(string n, logic [7:0] i, logic [7:0] e);
		bus(0, i, 0);
		chk(n, rv, {24'h00_0000, e});
	endtask
	initial
	begin
		void'($urandom(32'h353c2bb9));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		clk_error_i <= 1;
		rdc("page", 8'h00, 8'h00);
		rdc("live page0", 8'h2C, 8'h00);
		bus(1, 8'h00, 8'h01);
		rdc("cfg", 8'h16, 8'h00);
		rdc("summary", 8'h2D, 8'h00);
		bus(1, 8'h2C, 8'h70);
		rdc("live", 8'h2C, 8'h80);
		rdc("unmapped", 8'h17, 8'h00);
		// Random config writes, some with the byte lane off
		repeat (24)
		begin
			r2 = $urandom;
			{clk_error_i, pll_lock_i, over_temp_i, over_current_i,
				vbat_short_low_i, auto_sink_code_i} <= r2[7:0];
			ch1_faults_i <= r2[15:8] & {8{r2[16]}};
			ch2_faults_i <= r2[31:24] & {8{r2[17]}};
			s = r2[18];
			d = r2[23:16] & 8'hF0;
			bus(1, 8'h16, d, s);
			if (s)
				cfg = d;
			rdc("cfg", 8'h16, cfg);
			chk("mode", sink_manual_mode_o, cfg[7]);
			// Expected code from the model, not from the design's outputs
			ec = cfg[7] ? cfg[6:4] : auto_sink_code_i;
			chk("code", sink_code_o, ec);
			chk("ua", sink_current_ua_o, 4300 * ec);
			rdc("live", 8'h2C, r2[7:4] << 4);
			rdc("summary", 8'h2D, {|ch1_faults_i, |ch2_faults_i, 4'h0,
				vbat_short_low_i, 1'b0});
		end
		{clk_error_i, pll_lock_i, over_temp_i, over_current_i} <= 0;
		bus(1, 8'h41, 8'h20);
		bus(1, 8'h40, 8'h3F);
		clk_error_i <= 1;
		repeat (5) @(posedge clk_i);
		chk("irq set", irq_o, 1);
		clk_error_i <= 0;
		bus(1, 8'h41, 8'h00);
		chk("irq masked", irq_o, 0);
		bus(1, 8'h41, 8'h20);
		chk("irq sticky", irq_o, 1);
		bus(1, 8'h40, 8'h20);
		chk("irq clear", irq_o, 0);
		bus(1, 8'h00, 8'hFF);
		chk("page", page_o, 8'hFF);
		rdc("cfg page255", 8'h16, 8'h00);
		// Mid-run reset must return page and sink config to zero
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		chk("page rst", page_o, 8'h00);
		bus(1, 8'h00, 8'h01);
		rdc("cfg rst", 8'h16, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire

// ### wb_host.sv
// Purpose: Wishbone host model for the register bank
// Assumes: Classic single cycles, one at a time, cyc and stb together
// Notes: Gives up after 50 cycles without ack and says so
`default_nettype none
module wb_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] rdat_i,
	output var logic cyc_o,
	output var logic we_o,
	output var logic [9:0] adr_o,
	output var logic [3:0] sel_o,
	output var logic [31:0] wdat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {cyc_o, we_o, adr_o, sel_o, wdat_o} = '0;
	// Request held until the ack edge so the bank never sees it change
	task automatic xfer(input logic w, input logic [7:0] i,
		input logic [7:0] d, input logic s, output logic [31:0] r,
		output bit to);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		we_o <= w;
		adr_o <= {i, 2'h0};
		sel_o <= {3'h0, s};
		wdat_o <= {24'h00_0000, d};
		@(posedge clk_i);
		while (ack_i !== 1'b1 && n < 50)
		begin
			@(posedge clk_i);
			n++;
		end
		r = rdat_i;
		to = n >= 50;
		cyc_o <= 1'b0;
	endtask
endmodule
`default_nettype wire
